//--- scfp_pkg.sv
// Shared constants and types of the serial command frame port, both ends.
package scfp_pkg;
	// Reference clock period of both ends
	localparam int REF_PERIOD_NS = 100;
	// Frame geometry, most significant bit first
	localparam int FRAME_BITS = 16;
	localparam int MIN_FRAME_BITS = 16;
	localparam int CMD_HI = 15;
	localparam int CMD_LO = 14;
	localparam int ADDR_HI = 13;
	localparam int ADDR_LO = 8;
	localparam int DATA_HI = 7;
	localparam int TAIL_HI = 1;
	// Bit count one short of the least legal length; the next falling edge sets the length flag
	localparam logic [7:0] LONG_MARK = 8'(MIN_FRAME_BITS - 1);
	// Leading bit pairs of a command frame
	localparam logic [1:0] CMD_READ_BAD = 2'h0;
	localparam logic [1:0] CMD_READ = 2'h1;
	localparam logic [1:0] CMD_WRITE = 2'h2;
	localparam logic [1:0] CMD_WRITE_BAD = 2'h3;
	// Trailing bit pairs of read style frames
	localparam logic [1:0] TAIL_DIAG = 2'h1;
	localparam logic [1:0] TAIL_READ = 2'h2;
	// Leading bit pair of a register read answer
	localparam logic [1:0] RESP_READ_TAG = 2'h2;
	// Register locations, primary field then secondary field
	localparam logic [5:0] ADDR_OUT = 6'h00;
	localparam logic [5:0] ADDR_MAPIN0 = 6'h04;
	localparam logic [5:0] ADDR_MAPIN1 = 6'h05;
	localparam logic [5:0] ADDR_INPUT_STATUS_REGISTER = 6'h06;
	// Register reset values
	localparam logic [7:0] RST_OUT = 8'h00;
	localparam logic [7:0] RST_MAPIN0 = 8'h04;
	localparam logic [7:0] RST_MAPIN1 = 8'h08;
	// Position of the transmission error flag
	localparam int DIAG_TER_BIT = 10;
	localparam int INPUT_STATUS_REGISTER_TER_BIT = 7;
	// Host link timing in nanoseconds
	localparam int T_LEAD_NS = 200;
	localparam int T_LAG_NS = 200;
	localparam int T_TD_NS = 250;
	localparam int T_SCLK_HALF_NS = 500;
	localparam int T_TURN_NS = 1000;
	// Timing in reference cycles, least times rounded up
	localparam int LEAD_CYC = (T_LEAD_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int LAG_CYC = (T_LAG_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int HALF_CYC = (T_SCLK_HALF_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	localparam int GAP_NS = (T_TD_NS > T_TURN_NS) ? T_TD_NS : T_TURN_NS;
	localparam int GAP_CYC = (GAP_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;
	// Host sequencer states
	typedef enum logic [2:0] {
		SCFP_IDLE = 3'b000,
		SCFP_LEAD = 3'b001,
		SCFP_HIGH = 3'b010,
		SCFP_LOW = 3'b011,
		SCFP_LAG = 3'b100,
		SCFP_GAP = 3'b101
	} scfp_state_e;
endpackage

//--- scfp_if.sv
// Link wires between the host and the switch device.
`timescale 1ns/10ps
interface scfp_if;
	logic sclk; // Serial clock, made by the host
	logic chip_select_low_n; // Frame select, low while selected
	logic mosi; // Serial data towards the device
	logic miso; // Serial data driven by the device
	logic miso_oe; // High while the device drives its output
	wire so_line; // Resolved level of the device output pin
	// Released pin has no pull, so it shows the inverse to catch a host that trusts it
	assign so_line = miso_oe ? miso : ~miso;
	modport dev (input sclk, input chip_select_low_n, input mosi, output miso, output miso_oe);
	modport host (output sclk, output chip_select_low_n, output mosi, input so_line);
endinterface // scfp_if

//--- scfp_device.sv
// Switch device end: frame decode, delayed answer and register set.
// Contract
// - Answer comes out in the next frame
// - Host remembers previous command to read answers
// - Bad clock count flags error next answer
// - First answer after reset ignores prior frame
// - Leading 11 is a rejected write
// - Leading 00 is a rejected read
// - Unused locations rejected, registers left unchanged
// - Write frame layout, answered with diagnosis
// - Read frame layout ending in 10
// - Read answer: 10, address, register content
// - Zero start, 01 end returns diagnosis
// - Reset answer: error flag plus input status
`timescale 1ns/10ps
module scfp_device import scfp_pkg::*; (
	// Reference clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Link to the host
	scfp_if.dev link,
	// Device status from the switch core
	input wire logic i_soft_reset,
	input wire logic [14:0] i_diag_status,
	input wire logic [6:0] i_input_status,
	// Register contents and events
	output logic [7:0] o_out_ctrl,
	output logic [7:0] o_map_in0,
	output logic [7:0] o_map_in1,
	output logic o_tx_error,
	output logic o_cmd_err
);

	// Link domain state, clocked by the serial clock and the select rise
	logic fresh_q; // Set while deselected, cleared by first sample
	logic [7:0] cnt_q; // Falling edges seen in the frame
	logic long_q; // Frame has reached the least legal length
	logic [15:0] rx_q; // Last sixteen bits sampled
	logic [4:0] idx_q; // Output bit index
	logic armed_q; // First rising edge has passed
	logic ran_q; // Closed frame saw at least one falling edge

	// Reference domain state
	logic [2:0] cs_s_q; // Select synchroniser chain
	logic cs_f_q; // Filtered select level
	logic ter_q; // Previous transmission failed
	logic [15:0] tx_q; // Answer for the next frame
	logic [7:0] out_ctrl_q; // Output control register
	logic [7:0] map_in0_q; // Input pin 0 mapping register
	logic [7:0] map_in1_q; // Input pin 1 mapping register
	logic cmd_err_q; // Syntax error pulse

	// Decode of the finished frame
	logic frame_end; // One cycle when a frame has closed
	logic frame_ok; // Clock count legal
	logic [1:0] cmd; // Leading bit pair
	logic [1:0] tail; // Trailing bit pair
	logic [5:0] addr; // Both address fields
	logic [2:0] sel; // Valid flag and register slot
	logic is_write; // Legal write to a writable location
	logic is_read; // Legal read of an implemented location
	logic is_diag; // Diagnosis request
	logic [7:0] rd_data; // Content of the addressed register

	// Standard diagnosis word with our error flag at its slot
	function automatic logic [15:0] diag_word(input logic transmission_error_flag);
		logic [15:0] w;
		w = {1'b0, i_diag_status};
		w[DIAG_TER_BIT] = transmission_error_flag;
		return w;
	endfunction

	// Input status byte with the error flag in its top bit
	function automatic logic [7:0] input_status_register_byte(input logic transmission_error_flag);
		logic [7:0] b;
		b = {1'b0, i_input_status};
		b[INPUT_STATUS_REGISTER_TER_BIT] = transmission_error_flag;
		return b;
	endfunction

	// Address to register slot; bit 2 marks an implemented location
	function automatic logic [2:0] reg_sel(input logic [5:0] a);
		case (a)
			ADDR_OUT: reg_sel = 3'h4;
			ADDR_MAPIN0: reg_sel = 3'h5;
			ADDR_MAPIN1: reg_sel = 3'h6;
			ADDR_INPUT_STATUS_REGISTER: reg_sel = 3'h7;
			default: reg_sel = 3'h0;
		endcase
	endfunction

	// Frame start marker; select high sets it, so a new frame restarts counting
	always_ff @(negedge link.sclk or posedge link.chip_select_low_n) begin
		if (link.chip_select_low_n) begin
			fresh_q <= 1'b1;
		end else begin
			fresh_q <= 1'b0;
		end
	end

	// Capture at the select rise whether the frame was clocked at all; the start marker
	// is set again by that same rise, so the other domain cannot read it afterwards
	always_ff @(posedge link.chip_select_low_n) begin
		ran_q <= !fresh_q;
	end

	// Bit counter and length flag, kept after the frame so the other domain can read them
	always_ff @(negedge link.sclk) begin
		if (fresh_q) begin
			cnt_q <= 8'h01;
			long_q <= 1'b0;
		end else begin
			cnt_q <= cnt_q + 8'h01;
			if (cnt_q == LONG_MARK) begin
				long_q <= 1'b1;
			end
		end
	end

	// Input shift register, sampled on falling edges
	always_ff @(negedge link.sclk) begin
		rx_q <= {rx_q[14:0], link.mosi};
	end

	// Output index advances on rising edges after the first one
	always_ff @(posedge link.sclk or posedge link.chip_select_low_n) begin
		if (link.chip_select_low_n) begin
			idx_q <= 5'h00;
			armed_q <= 1'b0;
		end else begin
			armed_q <= 1'b1;
			if (armed_q && !idx_q[4]) begin
				idx_q <= idx_q + 5'h01;
			end
		end
	end

	// Bit 15 shows from select low; beyond sixteen bits the output sends zeros
	assign link.miso = idx_q[4] ? 1'b0 : tx_q[~idx_q[3:0]];
	assign link.miso_oe = ~link.chip_select_low_n;

	// Select synchroniser; only the second and third stages are looked at
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			cs_s_q <= 3'h7;
			cs_f_q <= 1'b1;
		end else begin
			cs_s_q <= {cs_s_q[1:0], link.chip_select_low_n};
			if (cs_s_q[1] == cs_s_q[2]) begin
				cs_f_q <= cs_s_q[2];
			end
		end
	end

	// Frame close seen once two stages agree on high
	assign frame_end = (cs_s_q[1] == cs_s_q[2]) && cs_s_q[2] && !cs_f_q;

	// Link state is still while deselected, so reading it here is safe
	assign frame_ok = ran_q && long_q && (cnt_q[2:0] == 3'h0);
	assign cmd = rx_q[CMD_HI:CMD_LO];
	assign tail = rx_q[TAIL_HI:0];
	assign addr = rx_q[ADDR_HI:ADDR_LO];
	assign sel = reg_sel(addr);

	// Writes need a writable slot; the status slot is read only
	assign is_write = (cmd == CMD_WRITE) && sel[2] && (addr != ADDR_INPUT_STATUS_REGISTER);
	// Reads need the 01 head, the 10 tail and an implemented slot
	assign is_read = (cmd == CMD_READ) && (tail == TAIL_READ) && sel[2];
	// A zero lead with a 01 tail asks for the diagnosis whatever lies between
	assign is_diag = !cmd[1] && (tail == TAIL_DIAG);

	// Register read mux
	always_comb begin
		case (sel[1:0])
			2'h0: rd_data = out_ctrl_q;
			2'h1: rd_data = map_in0_q;
			2'h2: rd_data = map_in1_q;
			default: rd_data = input_status_register_byte(1'b0);
		endcase
	end

	// Answer word and error flag, computed once per closed frame
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn || i_soft_reset) begin
			ter_q <= 1'b1;
			tx_q <= {RESP_READ_TAG, ADDR_INPUT_STATUS_REGISTER, input_status_register_byte(1'b1)};
		end else if (frame_end) begin
			if (!frame_ok) begin
				// Error answer replaces the answer to the previous command
				ter_q <= 1'b1;
				tx_q <= diag_word(1'b1);
			end else begin
				ter_q <= 1'b0;
				if (is_diag) begin
					tx_q <= diag_word(1'b0);
				end else if (is_write) begin
					tx_q <= diag_word(1'b0);
				end else if (is_read) begin
					tx_q <= {RESP_READ_TAG, addr, rd_data};
				end else begin
					// Syntax error answer carries the error flag
					tx_q <= diag_word(1'b1);
				end
			end
		end
	end

	// Syntax error event for the core
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			cmd_err_q <= 1'b0;
		end else begin
			cmd_err_q <= frame_end && frame_ok && !is_diag && !is_write && !is_read;
		end
	end

	// Writable registers change only on a legal write of a good frame
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn || i_soft_reset) begin
			out_ctrl_q <= RST_OUT;
			map_in0_q <= RST_MAPIN0;
			map_in1_q <= RST_MAPIN1;
		end else if (frame_end && frame_ok && is_write) begin
			case (sel[1:0])
				2'h0: out_ctrl_q <= rx_q[DATA_HI:0];
				2'h1: map_in0_q <= rx_q[DATA_HI:0];
				2'h2: map_in1_q <= rx_q[DATA_HI:0];
				default: out_ctrl_q <= out_ctrl_q;
			endcase
		end
	end

	// Outputs come straight from their flops
	assign o_out_ctrl = out_ctrl_q;
	assign o_map_in0 = map_in0_q;
	assign o_map_in1 = map_in1_q;
	assign o_tx_error = ter_q;
	assign o_cmd_err = cmd_err_q;

endmodule // scfp_device

//--- scfp_host.sv
// Host end: makes the serial clock and runs one sixteen bit frame per command.
`timescale 1ns/10ps
module scfp_host import scfp_pkg::*; (
	// Reference clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Link to the device
	scfp_if.host link,
	// Command request
	input wire logic i_cmd_valid,
	input wire logic [15:0] i_cmd_word,
	output logic o_cmd_ready,
	// Answer
	output logic o_rsp_valid,
	output logic [15:0] o_rsp_word,
	output logic [15:0] o_rsp_prev_cmd
);

	scfp_state_e state_q; // Sequencer state
	logic [3:0] tmr_q; // Phase timer, counts down
	logic [3:0] bit_q; // Bits clocked in this frame
	logic [15:0] tx_q; // Outgoing shift register
	logic [15:0] rx_q; // Incoming shift register
	logic [15:0] cur_q; // Command of this frame
	logic [15:0] prev_q; // Command of the frame before
	logic sclk_q; // Serial clock level
	logic cs_q; // Select level, low active
	logic ready_q; // Ready for a command
	logic [2:0] so_s_q; // Device output synchroniser
	logic so_f_q; // Filtered device output
	logic rsp_valid_q; // Answer pulse
	logic [15:0] rsp_q; // Answer word
	logic take; // Command accepted this cycle

	assign take = (state_q == SCFP_IDLE) && ready_q && i_cmd_valid;

	// Device output passes three flops; a change counts when the last two agree
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			so_s_q <= 3'h0;
			so_f_q <= 1'b0;
		end else begin
			so_s_q <= {so_s_q[1:0], link.so_line};
			if (so_s_q[1] == so_s_q[2]) begin
				so_f_q <= so_s_q[2];
			end
		end
	end

	// Frame sequencer; the half period covers the synchroniser delay before each sample
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			state_q <= SCFP_IDLE;
			tmr_q <= 4'h0;
			bit_q <= 4'h0;
			tx_q <= 16'h0000;
			rx_q <= 16'h0000;
			sclk_q <= 1'b0;
			cs_q <= 1'b1;
		end else begin
			case (state_q)
				SCFP_IDLE: begin
					if (take) begin
						cs_q <= 1'b0;
						tx_q <= i_cmd_word;
						bit_q <= 4'h0;
						tmr_q <= 4'(LEAD_CYC - 1);
						state_q <= SCFP_LEAD;
					end
				end
				SCFP_LEAD: begin
					if (tmr_q == 4'h0) begin
						sclk_q <= 1'b1;
						tmr_q <= 4'(HALF_CYC - 1);
						state_q <= SCFP_HIGH;
					end else begin
						tmr_q <= tmr_q - 4'h1;
					end
				end
				SCFP_HIGH: begin
					if (tmr_q == 4'h0) begin
						// Falling edge: both ends sample here
						sclk_q <= 1'b0;
						rx_q <= {rx_q[14:0], so_f_q};
						bit_q <= bit_q + 4'h1;
						if (bit_q == 4'hF) begin
							tmr_q <= 4'(LAG_CYC - 1);
							state_q <= SCFP_LAG;
						end else begin
							tmr_q <= 4'(HALF_CYC - 1);
							state_q <= SCFP_LOW;
						end
					end else begin
						tmr_q <= tmr_q - 4'h1;
					end
				end
				SCFP_LOW: begin
					// Data moves one cycle after the fall to keep hold time
					if (tmr_q == 4'(HALF_CYC - 1)) begin
						tx_q <= {tx_q[14:0], 1'b0};
					end
					if (tmr_q == 4'h0) begin
						sclk_q <= 1'b1;
						tmr_q <= 4'(HALF_CYC - 1);
						state_q <= SCFP_HIGH;
					end else begin
						tmr_q <= tmr_q - 4'h1;
					end
				end
				SCFP_LAG: begin
					if (tmr_q == 4'h0) begin
						cs_q <= 1'b1;
						tmr_q <= 4'(GAP_CYC - 1);
						state_q <= SCFP_GAP;
					end else begin
						tmr_q <= tmr_q - 4'h1;
					end
				end
				SCFP_GAP: begin
					// Gap also gives the device time to prepare its next answer
					if (tmr_q == 4'h0) begin
						state_q <= SCFP_IDLE;
					end else begin
						tmr_q <= tmr_q - 4'h1;
					end
				end
				default: begin
					state_q <= SCFP_IDLE;
				end
			endcase
		end
	end

	// Ready only while idle and not taking
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			ready_q <= 1'b0;
		end else begin
			ready_q <= (state_q == SCFP_IDLE) && !take;
		end
	end

	// Command history so each answer is paired with the command it answers
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			cur_q <= 16'h0000;
			prev_q <= 16'h0000;
		end else if (take) begin
			prev_q <= cur_q;
			cur_q <= i_cmd_word;
		end
	end

	// Answer pulse when select rises
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			rsp_valid_q <= 1'b0;
			rsp_q <= 16'h0000;
		end else begin
			rsp_valid_q <= (state_q == SCFP_LAG) && (tmr_q == 4'h0);
			if ((state_q == SCFP_LAG) && (tmr_q == 4'h0)) begin
				rsp_q <= rx_q;
			end
		end
	end

	assign link.sclk = sclk_q;
	assign link.chip_select_low_n = cs_q;
	assign link.mosi = tx_q[15];
	assign o_cmd_ready = ready_q;
	assign o_rsp_valid = rsp_valid_q;
	assign o_rsp_word = rsp_q;
	assign o_rsp_prev_cmd = prev_q;

endmodule // scfp_host

//--- scfp_assertions.sv
// Assertions on the wires between host and device.
`timescale 1ns/10ps
module scfp_assertions (
	// Reference clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Link wires
	input wire logic sclk,
	input wire logic chip_select_low_n,
	input wire logic mosi,
	input wire logic miso,
	input wire logic miso_oe
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_resetn);
	logic [7:0] falls_q; // Falling serial edges seen in this frame
	// Count falls; deselect clears, so no reset is needed
	always_ff @(posedge i_ref_clk) begin
		if (chip_select_low_n) begin
			falls_q <= 8'h00;
		end else if ($past(sclk) && !sclk) begin
			falls_q <= falls_q + 8'h01;
		end
	end
	chk_oe_select: assert property (miso_oe == !chip_select_low_n)
		else $error("output enable differs from select");
	chk_sclk_idle: assert property (chip_select_low_n |-> !sclk)
		else $error("serial clock moves while deselected");
	chk_lead_time: assert property ($fell(chip_select_low_n) |-> !sclk [*2])
		else $error("lead time too short");
	chk_lag_time: assert property ($rose(chip_select_low_n) |-> !$past(sclk) && !$past(sclk, 2))
		else $error("lag time too short");
	chk_gap_time: assert property ($rose(chip_select_low_n) |=> chip_select_low_n [*8])
		else $error("gap between frames too short");
	chk_high_time: assert property ($rose(sclk) |=> sclk [*4])
		else $error("serial clock high time too short");
	chk_mosi_stable: assert property (sclk |-> $stable(mosi))
		else $error("host data moves while clock high");
	chk_miso_stable: assert property (!chip_select_low_n && $past(!chip_select_low_n) && !sclk |-> $stable(miso))
		else $error("device data moves while clock low");
	chk_frame_bits: assert property ($rose(chip_select_low_n) |-> falls_q == 8'h10)
		else $error("host frame is not sixteen bits");
endmodule // scfp_assertions

//--- tb_spi_command_frame_protocol.sv
// Self-checking bench: host and device joined, plus a faulty link to a second device.
`timescale 1ns/10ps
module tb_spi_command_frame_protocol import scfp_pkg::*;;
	logic i_ref_clk, i_resetn, i_soft_reset, i_cmd_valid, o_cmd_ready, o_rsp_valid;
	logic [15:0] i_cmd_word, o_rsp_word, o_rsp_prev_cmd, m_ans, prev, rst_ans, g;
	logic [14:0] i_diag_status;
	logic [6:0] i_input_status;
	logic [7:0] o_out_ctrl, o_map_in0, o_map_in1;
	logic o_tx_error, o_cmd_err, tx_err2, m_ter;
	logic [7:0] m_reg [3]; // Model of the three writable registers
	logic [31:0] seed = 32'd39334;
	int miscompares = 0, samples_checked = 0, err_pulses = 0, err_model = 0, have_prev = 0;
	// Fixed-order commands: every code, tail and boundary address
	logic [15:0] dir [14] = '{16'h8055, 16'h84A3, 16'h853C, 16'h4002, 16'h4402, 16'h4502, 16'h4602,
		16'h8612, 16'hC055, 16'h0002, 16'h0001, 16'h7FFD, 16'h4F02, 16'h4000};
	scfp_if lnk();
	scfp_if lnk2(); // Bench drives this one to break framing on purpose
	scfp_host scfp_host_i(.i_ref_clk, .i_resetn, .link(lnk.host), .i_cmd_valid, .i_cmd_word, .o_cmd_ready,
		.o_rsp_valid, .o_rsp_word, .o_rsp_prev_cmd);
	scfp_device scfp_device_i(.i_ref_clk, .i_resetn, .link(lnk.dev), .i_soft_reset, .i_diag_status,
		.i_input_status, .o_out_ctrl, .o_map_in0, .o_map_in1, .o_tx_error, .o_cmd_err);
	scfp_device scfp_device_fault_i(.i_ref_clk, .i_resetn, .link(lnk2.dev), .i_soft_reset(1'b0),
		.i_diag_status, .i_input_status, .o_out_ctrl(), .o_map_in0(), .o_map_in1(), .o_tx_error(tx_err2),
		.o_cmd_err());
	scfp_assertions scfp_assertions_i(.i_ref_clk, .i_resetn, .sclk(lnk.sclk),
		.chip_select_low_n(lnk.chip_select_low_n), .mosi(lnk.mosi), .miso(lnk.miso), .miso_oe(lnk.miso_oe));
	// Reference clock
	initial begin
		i_ref_clk = 1'b0;
		forever #50 i_ref_clk = ~i_ref_clk;
	end
	// Syntax error pulses, counted against the model
	always @(posedge i_ref_clk) if (o_cmd_err === 1'b1) err_pulses++;
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			miscompares++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function automatic logic [15:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[15:0];
	endfunction
	// Diagnosis word with the error flag forced
	function automatic logic [15:0] diag(input logic transmission_error_flag);
		logic [15:0] d;
		d = {1'b0, i_diag_status};
		d[DIAG_TER_BIT] = transmission_error_flag;
		return d;
	endfunction
	// Bounded wait; running out ends the run as a failure
	task automatic wait_hi(ref logic s);
		for (int n = 0; n < 400 && s !== 1'b1; n++) @(negedge i_ref_clk);
		if (s !== 1'b1) begin
			miscompares++;
			finish_test();
		end
	endtask
	// Decode one good-length frame into next answer and register effects
	task automatic model(input logic [15:0] c);
		logic [5:0] a;
		int k;
		a = c[13:8];
		k = (a == ADDR_OUT) ? 0 : (a == ADDR_MAPIN0) ? 1 : (a == ADDR_MAPIN1) ? 2 : (a == ADDR_INPUT_STATUS_REGISTER) ? 3 : 4;
		m_ter = 1'b0;
		m_ans = diag(1'b0);
		if (c[15:14] == CMD_WRITE && k < 3) m_reg[k] = c[7:0];
		else if (c[15:14] == CMD_READ && c[1:0] == TAIL_READ && k < 4)
			m_ans = {RESP_READ_TAG, a, (k == 3) ? {m_ter, i_input_status} : m_reg[k]};
		else if (c[15] || c[1:0] != TAIL_DIAG) begin
			m_ans = diag(1'b1);
			err_model++;
		end
	endtask
	// One command through the host, answer compared with the model
	task automatic send(input logic [15:0] c);
		wait_hi(o_cmd_ready);
		check({o_out_ctrl, o_map_in0}, {m_reg[0], m_reg[1]});
		check({o_map_in1, 7'h00, o_tx_error}, {m_reg[2], 7'h00, m_ter});
		check(16'(err_pulses), 16'(err_model));
		i_diag_status = 15'(rnd());
		i_input_status = 7'(rnd());
		i_cmd_word = c;
		i_cmd_valid = 1'b1;
		@(negedge i_ref_clk);
		i_cmd_valid = 1'b0;
		wait_hi(o_rsp_valid);
		check(o_rsp_word, m_ans);
		if (have_prev != 0) check(o_rsp_prev_cmd, prev);
		model(c);
		prev = c;
		have_prev = 1;
	endtask
	// Bench-made frame of any length on the second link, 160 ns serial period
	task automatic frame2(input logic [15:0] w, input int bits);
		int j;
		lnk2.chip_select_low_n = 1'b0;
		#200;
		for (int i = 0; i < bits; i++) begin
			j = i - (bits - 16);
			lnk2.mosi = (j >= 0) ? w[15 - j] : 1'b0;
			#60 lnk2.sclk = 1'b1;
			#80;
			if (i < 16) g[15 - i] = lnk2.so_line;
			lnk2.sclk = 1'b0;
			#20;
		end
		#200 lnk2.chip_select_low_n = 1'b1;
		lnk2.mosi = ~lnk2.mosi; // Released data must not look held
		repeat (30) @(negedge i_ref_clk);
	endtask
	initial begin
		{i_resetn, i_soft_reset, i_cmd_valid, i_cmd_word} = '0;
		// Select low through reset; its later rise sets the second device's frame marker
		{lnk2.sclk, lnk2.mosi, lnk2.chip_select_low_n} = 3'b000;
		i_diag_status = 15'h5A5A;
		i_input_status = 7'h35;
		g = 16'h0000;
		repeat (10) @(negedge i_ref_clk);
		lnk2.chip_select_low_n = 1'b1;
		i_resetn = 1'b1;
		rst_ans = 16'h8680 | {9'h000, i_input_status};
		m_ans = rst_ans;
		m_reg = '{RST_OUT, RST_MAPIN0, RST_MAPIN1};
		m_ter = 1'b1;
		foreach (dir[n]) send(dir[n]);
		// Soft reset between frames restores registers and the reset answer
		wait_hi(o_cmd_ready);
		i_soft_reset = 1'b1;
		repeat (3) @(negedge i_ref_clk);
		i_soft_reset = 1'b0;
		m_ans = 16'h8680 | {9'h000, i_input_status};
		m_reg = '{RST_OUT, RST_MAPIN0, RST_MAPIN1};
		m_ter = 1'b1;
		have_prev = 0;
		send(16'h4002);
		for (int n = 0; n < 30; n++) begin
			g = rnd();
			if (g[2]) g[13:10] = {3'h0, g[10]};
			send(g);
		end
		wait_hi(o_cmd_ready);
		// Framing on the second device: 8 clocks is a fault, 24 clocks is accepted
		frame2(16'h0001, 16);
		check(g, rst_ans);
		frame2(16'h0001, 8);
		check({15'h0000, tx_err2}, 16'h0001);
		frame2(16'h0001, 16);
		check(g, diag(1'b1));
		frame2(16'h0001, 24);
		check({15'h0000, tx_err2}, 16'h0000);
		frame2(16'h0001, 16);
		check(g, diag(1'b0));
		// Select pulse with no clock at all must still count as a failed transfer
		frame2(16'h0001, 0);
		check({15'h0000, tx_err2}, 16'h0001);
		finish_test();
	end
endmodule // tb_spi_command_frame_protocol
